// *** dv/nvmc_ctrl_sva.sv ***
// Purpose: Port checks for the flash command block
// Assumes: One clock, sync reset, one-cycle command latency
// Notes: Watches the register port and outputs; stimulus comes from the bench
`timescale 1ns/1ps
module nvmc_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  // Watched outputs
  input wire logic ready,
  input wire logic array_start,
  input wire logic [2:0] array_op,
  input wire logic [7:0] array_byte,
  input wire logic pbuf_clear,
  input wire logic cache_flush,
  input wire logic cache_off,
  input wire logic [3:0] miss_wait,
  input wire logic [3:0] hit_wait,
  input wire logic power_down
);
  // ====
  // Decoded writes; only ok leaves out busy writes, busy commands are refused
  logic wa;
  logic wb;
  logic ok;
  logic rsv;
  logic [6:0] c;
  assign wa = reg_sel && reg_wr && reg_addr == nvmc_pkg::OFS_CTRL_A;
  assign wb = reg_sel && reg_wr && reg_addr == nvmc_pkg::OFS_CTRL_B;
  assign ok = wa && ready && reg_wdata[15:8] == nvmc_pkg::EXEC_KEY;
  assign c = reg_wdata[6:0];
  assign rsv = !(c inside {7'h06, 7'h0F, 7'h1A, 7'h1C, [7'h40:7'h48]});
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Command path
  a_bad_key_idle: assert property (wa && reg_wdata[15:8] != nvmc_pkg::EXEC_KEY |=> !array_start)
    else $error("start after bad key");
  a_erase_op_start: assert property (ok && c == 7'h1A |=> array_start && array_op == 3'h3)
    else $error("erase not started");
  a_secure_zero_byte: assert property (array_start && array_op == 3'h5 |-> array_byte == 8'h00)
    else $error("secure byte not zero");
  a_wipe_one_pulse: assert property (ok && c == 7'h44 |=> pbuf_clear ##1 !pbuf_clear)
    else $error("wipe pulse wrong");
  a_flush_one_pulse: assert property (ok && c == 7'h46 |=> cache_flush ##1 !cache_flush)
    else $error("flush pulse wrong");
  a_power_set_now: assert property (ok && c == 7'h42 |=> power_down)
    else $error("power set ignored");
  a_reserved_quiet: assert property (ok && rsv |=> !array_start && !pbuf_clear && !cache_flush && $stable(power_down))
    else $error("reserved code acted");
  // ====
  // Control two fields
  a_cache_off_bit: assert property (wb |=> cache_off == $past(reg_wdata[18]))
    else $error("cache off wrong");
  a_mode_zero_wait: assert property (wb && reg_wdata[17:16] == 2'h0 |=> miss_wait == 4'h0 && hit_wait == 4'h0)
    else $error("mode zero waits");
  a_mode_low_power: assert property (wb && reg_wdata[17:16] == 2'h1 |=> miss_wait == 4'h1 && hit_wait == 4'h0)
    else $error("mode one waits");
  a_mode_uniform: assert property (wb && reg_wdata[17:16] == 2'h2 |=> miss_wait == $past(reg_wdata[4:1]) && hit_wait == miss_wait)
    else $error("mode two waits");
endmodule
bind nvmc_ctrl nvmc_ctrl_chk i_nvmc_ctrl_chk (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ready(ready), .array_start(array_start), .array_op(array_op),
  .array_byte(array_byte), .pbuf_clear(pbuf_clear), .cache_flush(cache_flush), .cache_off(cache_off),
  .miss_wait(miss_wait), .hit_wait(hit_wait), .power_down(power_down));

// *** dv/nvmc_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the flash command block
// Assumes: Inputs change 10 ns after the rising edge
// Notes: One idle cycle between register accesses
`timescale 1ns/1ps
module nvmc_ctrl_tb_top;
  // ====
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_secure = 1'b1;
  logic [31:0] reg_rdata;
  logic pbuf_wr = 1'b0;
  logic [21:0] pbuf_addr = 22'h00_1000;
  logic done;
  logic err;
  logic lrs;
  logic array_start;
  logic [2:0] array_op;
  logic [21:0] array_addr;
  logic [7:0] array_byte;
  logic [15:0] region_lock;
  logic [7:0] dregion_lock;
  logic ready;
  logic sec_ext_on = 1'b0;
  logic [7:0] dregion_secure = 8'h00;
  logic pbuf_clear;
  logic cache_flush;
  logic cache_off;
  logic [3:0] miss_wait;
  logic [3:0] hit_wait;
  logic [2:0] slp = 3'h0;
  logic power_down;
  logic slow = 1'b0;
  int fails = 0;
  int compares = 0;
  int starts = 0;
  int s0;
  logic [31:0] rv;
  logic [6:0] codes [5] = '{7'h06, 7'h0F, 7'h1A, 7'h1C, 7'h45};
  logic [6:0] rsv [6] = '{7'h00, 7'h07, 7'h1D, 7'h3F, 7'h49, 7'h7F};
  logic [3:0] mexp [4] = '{4'h0, 4'h1, 4'h5, 4'h0};
  always #50 clk = ~clk;
  // Count array starts so refusals can be seen
  always @(posedge clk) begin
    if (array_start === 1'b1) begin
      starts++;
    end
  end
  // ====
  // Design and flash model
  nvmc_ctrl i_nvmc_ctrl (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_secure(reg_secure), .reg_rdata(reg_rdata), .pbuf_wr(pbuf_wr),
    .pbuf_last(pbuf_wr), .pbuf_aux(1'b0), .pbuf_addr(pbuf_addr), .array_done(done), .array_err(err),
    .lockrow_secure(lrs), .array_start(array_start), .array_op(array_op), .array_addr(array_addr),
    .array_byte(array_byte), .region_lock(region_lock), .dregion_lock(dregion_lock), .ready(ready),
    .sec_ext_on(sec_ext_on), .dregion_secure(dregion_secure), .pbuf_clear(pbuf_clear),
    .cache_flush(cache_flush), .cache_off(cache_off), .miss_wait(miss_wait), .hit_wait(hit_wait),
    .sleep_enter(slp[2]), .sleep_exit(slp[1]), .mem_access(slp[0]), .power_down(power_down));
  nvmc_flash_model i_nvmc_flash_model (.clk(clk), .rst(rst), .slow(slow), .array_start(array_start),
    .array_done(done), .array_err(err), .lockrow_secure(lrs));
  // ====
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // Result and read data are settled when this returns
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    step(1);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_sel = 1'b0;
    rv = reg_rdata;
  endtask
  task automatic cmd(input logic [6:0] c);
    acc(1'b1, nvmc_pkg::OFS_CTRL_A, {16'h0000, nvmc_pkg::EXEC_KEY, 1'b0, c});
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    if (n == 50) begin
      fails++;
      end_of_test;
    end
  endtask
  task automatic pz(input logic [2:0] v);
    step(1);
    slp = v;
    step(1);
    slp = 3'h0;
    step(2);
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #10;
    rst = 1'b0;
    acc(1'b0, nvmc_pkg::OFS_CTRL_B, 32'h0000_0000);
    chk("ctrl_b", rv, nvmc_pkg::RST_CTRL_B);
    pbuf_wr = 1'b1;
    step(1);
    pbuf_wr = 1'b0;
    step(3);
    chk("auto_start", starts, 0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, nvmc_pkg::OFS_CTRL_B, 32'h0000_008A | (32'(m) << 16) | (32'(m & 1) << 18));
      chk("cache_off", cache_off, 32'(m & 1));
      chk("miss_wait", miss_wait, mexp[m]);
      chk("hit_wait", hit_wait, (m == 2) ? 32'h0000_0005 : 32'h0000_0000);
    end
    $display("test control two done");
    acc(1'b1, nvmc_pkg::OFS_CTRL_A, 32'h0000_5A1A);
    acc(1'b0, nvmc_pkg::OFS_STATUS, 32'h0000_0000);
    chk("prog_err", rv & 32'h0000_0004, 32'h0000_0004);
    chk("bad_key", starts, 0);
    acc(1'b1, nvmc_pkg::OFS_ADDR, 32'h0020_0000);
    for (int i = 0; i < 5; i++) begin
      slow = i[0];
      s0 = starts;
      cmd(codes[i]);
      chk("op", array_op, 32'(i + 1));
      if (i != 1 && i != 4) begin
        chk("addr", array_addr, 32'h0020_0000);
      end
      if (slow) begin
        cmd(nvmc_pkg::CMD_EE_PROG);
      end
      wait_ready;
      chk("one_start", starts - s0, 1);
    end
    acc(1'b0, nvmc_pkg::OFS_STATUS, 32'h0000_0000);
    chk("secure_bit", rv & 32'h0000_0100, 32'h0000_0100);
    cmd(nvmc_pkg::CMD_AUX_PROG);
    chk("aux_refused", array_start, 0);
    $display("test array commands done");
    acc(1'b1, nvmc_pkg::OFS_ADDR, 32'h0000_3500);
    cmd(nvmc_pkg::CMD_REGION_LOCK);
    chk("region", region_lock, 32'h0000_0008);
    cmd(nvmc_pkg::CMD_REGION_UNLOCK);
    chk("region", region_lock, 32'h0000_0000);
    cmd(nvmc_pkg::CMD_DREGION_LOCK);
    chk("dregion", dregion_lock, 32'h0000_0020);
    sec_ext_on = 1'b1;
    dregion_secure = 8'h20;
    reg_secure = 1'b0;
    cmd(nvmc_pkg::CMD_DREGION_UNLOCK);
    chk("dregion", dregion_lock, 32'h0000_0020);
    reg_secure = 1'b1;
    cmd(nvmc_pkg::CMD_DREGION_UNLOCK);
    chk("dregion", dregion_lock, 32'h0000_0000);
    reg_secure = 1'b0;
    cmd(nvmc_pkg::CMD_DREGION_LOCK);
    chk("dregion", dregion_lock, 32'h0000_0000);
    $display("test regions done");
    cmd(nvmc_pkg::CMD_BUF_WIPE);
    chk("wipe", pbuf_clear, 32'h0000_0001);
    cmd(nvmc_pkg::CMD_CACHE_FLUSH);
    chk("flush", cache_flush, 32'h0000_0001);
    cmd(nvmc_pkg::CMD_PRM_SET);
    chk("power", power_down, 32'h0000_0001);
    cmd(nvmc_pkg::CMD_PRM_CLEAR);
    chk("power", power_down, 32'h0000_0000);
    s0 = starts;
    foreach (rsv[k]) begin
      cmd(rsv[k]);
      chk("reserved", {array_start, pbuf_clear, cache_flush, power_down}, 32'h0000_0000);
    end
    chk("reserved_starts", starts - s0, 0);
    $display("test local commands done");
    acc(1'b1, nvmc_pkg::OFS_CTRL_B, 32'h0000_0080);
    pz(3'h4);
    chk("sleep_access", power_down, 32'h0000_0001);
    pz(3'h1);
    chk("sleep_access", power_down, 32'h0000_0000);
    acc(1'b1, nvmc_pkg::OFS_CTRL_B, 32'h0000_0180);
    pz(3'h4);
    chk("sleep_exit", power_down, 32'h0000_0001);
    pz(3'h2);
    chk("sleep_exit", power_down, 32'h0000_0000);
    acc(1'b1, nvmc_pkg::OFS_CTRL_B, 32'h0000_0300);
    pz(3'h4);
    chk("sleep_off", power_down, 32'h0000_0000);
    pbuf_wr = 1'b1;
    step(1);
    chk("auto_op", array_op, 32'h0000_0006);
    chk("auto_addr", array_addr, 32'h0000_1000);
    $display("test sleep done");
    end_of_test;
  end
endmodule

// *** dv/nvmc_flash_model.sv ***
// Purpose: Behavioural flash array answering start with done
// Assumes: Start is a one-cycle pulse
// Notes: Never fails an operation; part starts unsecured
`timescale 1ns/1ps
module nvmc_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Speed select
  input wire logic slow,
  // Array handshake
  input wire logic array_start,
  output logic array_done,
  output logic array_err,
  output logic lockrow_secure
);
  // ====
  // Busy countdown; slow mode opens a window for busy refusals
  logic [3:0] cnt;
  assign array_err = 1'b0;
  assign lockrow_secure = 1'b0;
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
    end else if (array_start) begin
      cnt <= slow ? 4'h6 : 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // One-cycle completion as the count runs out
  assign array_done = cnt == 4'h1 && !array_start;
endmodule

// *** shared/nvmc_pkg.sv ***
// Purpose: Shared constants and types for the flash command and read control block
// Assumes: 32-bit register words, byte offsets on the register port
// Notes: All offsets, field positions and reset values live here
package nvmc_pkg;
  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ADDR = 8'h1C;
  localparam logic [7:0] OFS_LOCK = 8'h20;
  localparam logic [31:0] RST_CTRL_B = 32'h0000_0080;
  localparam logic [7:0] EXEC_KEY = 8'hA5;
  localparam int unsigned ADDR_W = 22;
  // ==========================================================
  // Field positions
  localparam int unsigned CA_KEY_LO = 8;
  localparam int unsigned CB_RWS_LO = 1;
  localparam int unsigned CB_MANUAL = 7;
  localparam int unsigned CB_SLEEP_LO = 8;
  localparam int unsigned CB_TIMING_LO = 16;
  localparam int unsigned CB_CACHE_OFF = 18;
  localparam int unsigned ST_PRM = 0;
  localparam int unsigned ST_PERR = 2;
  localparam int unsigned ST_LOCKE = 3;
  localparam int unsigned ST_NVME = 4;
  localparam int unsigned ST_SB = 8;
  // ==========================================================
  // Command codes
  localparam logic [6:0] CMD_AUX_PROG = 7'h06;
  localparam logic [6:0] CMD_LOCKBIT_PROG = 7'h0F;
  localparam logic [6:0] CMD_EE_ERASE = 7'h1A;
  localparam logic [6:0] CMD_EE_PROG = 7'h1C;
  localparam logic [6:0] CMD_REGION_LOCK = 7'h40;
  localparam logic [6:0] CMD_REGION_UNLOCK = 7'h41;
  localparam logic [6:0] CMD_PRM_SET = 7'h42;
  localparam logic [6:0] CMD_PRM_CLEAR = 7'h43;
  localparam logic [6:0] CMD_BUF_WIPE = 7'h44;
  localparam logic [6:0] CMD_SECURE_SET = 7'h45;
  localparam logic [6:0] CMD_CACHE_FLUSH = 7'h46;
  localparam logic [6:0] CMD_DREGION_LOCK = 7'h47;
  localparam logic [6:0] CMD_DREGION_UNLOCK = 7'h48;
  // ==========================================================
  // Field encodings
  localparam logic [1:0] TIMING_ZERO_WAIT = 2'h0;
  localparam logic [1:0] TIMING_LOW_POWER = 2'h1;
  localparam logic [1:0] TIMING_UNIFORM = 2'h2;
  localparam logic [1:0] SLEEP_WAKE_ACCESS = 2'h0;
  localparam logic [1:0] SLEEP_WAKE_EXIT = 2'h1;
  localparam logic [7:0] SECURE_BYTE = 8'h00;
  // Array operations handed to the flash arrays
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_AUX_PROG = 3'b001,
    OP_LOCKBIT_PROG = 3'b010,
    OP_EE_ERASE = 3'b011,
    OP_EE_PROG = 3'b100,
    OP_SECURE_SET = 3'b101,
    OP_PAGE_PROG = 3'b110
  } nvmc_op_t;
  typedef enum logic [0:0] {
    FS_IDLE = 1'b0,
    FS_BUSY = 1'b1
  } nvmc_fsm_t;
endpackage

// *** src/nvmc_cmd_decode.sv ***
// Purpose: Decode a command code into an array operation or a local action
// Assumes: Pure combinational, used by the command path
// Notes: Unknown codes decode to nothing at all
`timescale 1ns/1ps
module nvmc_cmd_decode (
  // Command code
  input wire logic [6:0] cmd,
  // Decoded actions
  output nvmc_pkg::nvmc_op_t op,
  output logic lock_rg,
  output logic unlock_rg,
  output logic lock_dr,
  output logic unlock_dr,
  output logic prm_set,
  output logic prm_clr,
  output logic buf_wipe,
  output logic flush
);
  // ==========================================================
  // Decode table
  always_comb begin
    op = nvmc_pkg::OP_NONE;
    lock_rg = 1'b0;
    unlock_rg = 1'b0;
    lock_dr = 1'b0;
    unlock_dr = 1'b0;
    prm_set = 1'b0;
    prm_clr = 1'b0;
    buf_wipe = 1'b0;
    flush = 1'b0;
    case (cmd)
      nvmc_pkg::CMD_AUX_PROG: op = nvmc_pkg::OP_AUX_PROG;
      nvmc_pkg::CMD_LOCKBIT_PROG: op = nvmc_pkg::OP_LOCKBIT_PROG;
      nvmc_pkg::CMD_EE_ERASE: op = nvmc_pkg::OP_EE_ERASE;
      nvmc_pkg::CMD_EE_PROG: op = nvmc_pkg::OP_EE_PROG;
      nvmc_pkg::CMD_REGION_LOCK: lock_rg = 1'b1;
      nvmc_pkg::CMD_REGION_UNLOCK: unlock_rg = 1'b1;
      nvmc_pkg::CMD_PRM_SET: prm_set = 1'b1;
      nvmc_pkg::CMD_PRM_CLEAR: prm_clr = 1'b1;
      nvmc_pkg::CMD_BUF_WIPE: buf_wipe = 1'b1;
      nvmc_pkg::CMD_SECURE_SET: op = nvmc_pkg::OP_SECURE_SET;
      nvmc_pkg::CMD_CACHE_FLUSH: flush = 1'b1;
      nvmc_pkg::CMD_DREGION_LOCK: lock_dr = 1'b1;
      nvmc_pkg::CMD_DREGION_UNLOCK: unlock_dr = 1'b1;
      default: op = nvmc_pkg::OP_NONE;
    endcase
  end
endmodule

// *** src/nvmc_ctrl.sv ***
// Purpose: Command decoding, array sequencing and read/power control for the flash
// Assumes: Register port and array handshake run on clk; one word per access
// Notes: Region lock bits read back as one while the region is locked
`timescale 1ns/1ps
// Behaviour
// - Commands run only with key A5 in the same write; else programming error.
// - Code 06 programs aux page; only secure bit clear, user row only.
// - Code 0F programs lockbits from the lock register.
// - Code 1A erases addressed row of the emulation array.
// - Code 1C programs page buffer into addressed emulation array page.
// - Code 40 locks the main region holding the address.
// - Code 41 unlocks the main region holding the address.
// - Code 42 sets power reduction, code 43 clears it.
// - Code 44 clears the whole page buffer.
// - Code 45 sets the security bit by writing 00 to lockbit row.
// - Code 46 invalidates every read cache line.
// - Code 47 locks data region; secure regions need secure access.
// - Code 48 unlocks data region; secure regions need secure access.
// - Control two bit 18 disables the read cache.
// - Timing field 0 adds no wait state on a miss.
// - Timing field 1 saves power, one wait state per miss.
// - Timing field 2 makes hits and misses equal flash wait; 3 reserved.
// - Sleep field 0 wakes at first access; 3 disables auto power reduction.
// - Sleep field 1 wakes on sleep exit; 2 reserved.
// - Manual bit zero: last buffer word write starts page programming.
// - Manual bit one by default: programming only by explicit command.
module nvmc_ctrl #(
  parameter int unsigned REGIONS = 16,
  parameter int unsigned REGION_SHIFT = 12,
  parameter int unsigned DREGIONS = 8,
  parameter int unsigned DREGION_SHIFT = 8,
  parameter logic [21:0] USER_ROW_ADDR = 22'h20_0000,
  parameter int unsigned ROW_SHIFT = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_secure,
  output logic [31:0] reg_rdata,
  // Page buffer writes
  input wire logic pbuf_wr,
  input wire logic pbuf_last,
  input wire logic pbuf_aux,
  input wire logic [21:0] pbuf_addr,
  // Flash array handshake
  input wire logic array_done,
  input wire logic array_err,
  input wire logic lockrow_secure,
  output logic array_start,
  output logic [2:0] array_op,
  output logic [21:0] array_addr,
  output logic [7:0] array_byte,
  output logic [REGIONS-1:0] region_lock,
  output logic [DREGIONS-1:0] dregion_lock,
  output logic ready,
  // Security extension
  input wire logic sec_ext_on,
  input wire logic [DREGIONS-1:0] dregion_secure,
  // Page buffer and cache
  output logic pbuf_clear,
  output logic cache_flush,
  output logic cache_off,
  output logic [3:0] miss_wait,
  output logic [3:0] hit_wait,
  // Power
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic mem_access,
  output logic power_down
);
  // ==========================================================
  // Helpers
  function automatic logic [7:0] region_of(input logic [21:0] a, input int unsigned sh);
    logic [21:0] s;
    s = a >> sh;
    return s[7:0];
  endfunction
  // ==========================================================
  // State
  nvmc_pkg::nvmc_fsm_t fsm_reg, fsm_next;
  nvmc_pkg::nvmc_op_t op_reg, op_next;
  logic [6:0] cmd_reg, cmd_next;
  logic [31:0] ctrl_b_reg, ctrl_b_next;
  logic [21:0] addr_reg, addr_next;
  logic [21:0] aaddr_reg, aaddr_next;
  logic [REGIONS-1:0] rl_reg, rl_next;
  logic [DREGIONS-1:0] dl_reg, dl_next;
  logic prm_reg, prm_next;
  logic perr_reg, perr_next;
  logic locke_reg, locke_next;
  logic nvme_reg, nvme_next;
  logic sb_reg, sb_next;
  logic boot_reg, boot_next;
  logic start_reg, start_next;
  logic wipe_reg, wipe_next;
  logic flush_reg, flush_next;
  logic pd_reg, pd_next;
  logic ready_reg, ready_next;
  logic [3:0] mw_reg, mw_next;
  logic [3:0] hw_reg, hw_next;
  logic [31:0] rdata_reg, rdata_next;
  // Decoder and sleep power outputs
  nvmc_pkg::nvmc_op_t dec_op;
  logic dec_lock, dec_unlock, dec_dlock, dec_dunlock;
  logic dec_pset, dec_pclr, dec_wipe, dec_flush;
  logic sleep_lp;
  nvmc_cmd_decode u_dec (
    .cmd(reg_wdata[6:0]),
    .op(dec_op),
    .lock_rg(dec_lock),
    .unlock_rg(dec_unlock),
    .lock_dr(dec_dlock),
    .unlock_dr(dec_dunlock),
    .prm_set(dec_pset),
    .prm_clr(dec_pclr),
    .buf_wipe(dec_wipe),
    .flush(dec_flush)
  );
  nvmc_sleep_power u_sleep (
    .clk(clk),
    .rst(rst),
    .sleep_power_field(ctrl_b_reg[nvmc_pkg::CB_SLEEP_LO +: 2]),
    .sleep_enter(sleep_enter),
    .sleep_exit(sleep_exit),
    .mem_access(mem_access),
    .low_power(sleep_lp)
  );
  // ==========================================================
  // Next-state logic
  always_comb begin
    logic wr, ca_wr, key_ok, busy, aux_ok, auto_go, dr_ok;
    logic [7:0] ri, di;
    wr = reg_sel && reg_wr;
    ca_wr = wr && (reg_addr == nvmc_pkg::OFS_CTRL_A);
    key_ok = reg_wdata[nvmc_pkg::CA_KEY_LO +: 8] == nvmc_pkg::EXEC_KEY;
    busy = (fsm_reg == nvmc_pkg::FS_BUSY);
    ri = region_of(addr_reg, REGION_SHIFT);
    di = region_of(addr_reg, DREGION_SHIFT);
    aux_ok = !sb_reg && ((addr_reg >> ROW_SHIFT) == (USER_ROW_ADDR >> ROW_SHIFT));
    dr_ok = !sec_ext_on || !dregion_secure[di[$clog2(DREGIONS)-1:0]] || reg_secure;
    auto_go = pbuf_wr && pbuf_last && !ctrl_b_reg[nvmc_pkg::CB_MANUAL];
    fsm_next = fsm_reg;
    op_next = op_reg;
    cmd_next = cmd_reg;
    ctrl_b_next = ctrl_b_reg;
    addr_next = addr_reg;
    aaddr_next = aaddr_reg;
    rl_next = rl_reg;
    dl_next = dl_reg;
    prm_next = prm_reg;
    perr_next = perr_reg;
    locke_next = locke_reg;
    nvme_next = nvme_reg;
    sb_next = sb_reg;
    boot_next = 1'b0;
    start_next = 1'b0;
    wipe_next = 1'b0;
    flush_next = 1'b0;
    rdata_next = rdata_reg;
    // Security bit is loaded from the lockbit row once after reset
    if (boot_reg) begin
      sb_next = lockrow_secure;
    end
    // Plain register writes; status clears come first so a same-cycle set wins
    if (wr && reg_addr == nvmc_pkg::OFS_CTRL_B) begin
      ctrl_b_next = reg_wdata & 32'h0007_039E;
    end
    if (wr && reg_addr == nvmc_pkg::OFS_ADDR) begin
      addr_next = reg_wdata[21:0];
    end
    if (wr && reg_addr == nvmc_pkg::OFS_STATUS) begin
      perr_next = perr_reg & ~reg_wdata[nvmc_pkg::ST_PERR];
      locke_next = locke_reg & ~reg_wdata[nvmc_pkg::ST_LOCKE];
      nvme_next = nvme_reg & ~reg_wdata[nvmc_pkg::ST_NVME];
    end
    // Array sequencer completion
    if (busy && array_done) begin
      fsm_next = nvmc_pkg::FS_IDLE;
      if (array_err) begin
        nvme_next = 1'b1;
      end
      if (op_reg == nvmc_pkg::OP_SECURE_SET) begin
        sb_next = 1'b1;
      end
    end
    // Command issue
    if (ca_wr) begin
      cmd_next = reg_wdata[6:0];
      if (!key_ok || busy) begin
        perr_next = 1'b1;
      end else begin
        if (dec_op != nvmc_pkg::OP_NONE) begin
          if (dec_op == nvmc_pkg::OP_AUX_PROG && !aux_ok) begin
            perr_next = 1'b1;
          end else begin
            // Explicit command starts the array operation
            fsm_next = nvmc_pkg::FS_BUSY;
            op_next = dec_op;
            aaddr_next = addr_reg;
            start_next = 1'b1;
          end
        end
        if (dec_lock) begin
          rl_next[ri[$clog2(REGIONS)-1:0]] = 1'b1;
        end
        if (dec_unlock) begin
          rl_next[ri[$clog2(REGIONS)-1:0]] = 1'b0;
        end
        if ((dec_dlock || dec_dunlock) && !dr_ok) begin
          locke_next = 1'b1;
        end else if (dec_dlock) begin
          dl_next[di[$clog2(DREGIONS)-1:0]] = 1'b1;
        end else if (dec_dunlock) begin
          dl_next[di[$clog2(DREGIONS)-1:0]] = 1'b0;
        end
        if (dec_pset) begin
          prm_next = 1'b1;
        end
        if (dec_pclr) begin
          prm_next = 1'b0;
        end
        wipe_next = dec_wipe;
        flush_next = dec_flush;
      end
    end else if (auto_go) begin
      // Automatic page programming; a command in the same cycle has priority
      if (busy) begin
        perr_next = 1'b1;
      end else begin
        fsm_next = nvmc_pkg::FS_BUSY;
        op_next = pbuf_aux ? nvmc_pkg::OP_AUX_PROG : nvmc_pkg::OP_PAGE_PROG;
        aaddr_next = pbuf_addr;
        start_next = 1'b1;
      end
    end
    // Cache timing outputs
    mw_next = 4'h0;
    hw_next = 4'h0;
    if (ctrl_b_next[nvmc_pkg::CB_TIMING_LO +: 2] == nvmc_pkg::TIMING_LOW_POWER) begin
      mw_next = 4'h1;
    end else if (ctrl_b_next[nvmc_pkg::CB_TIMING_LO +: 2] == nvmc_pkg::TIMING_UNIFORM) begin
      mw_next = ctrl_b_next[nvmc_pkg::CB_RWS_LO +: 4];
      hw_next = ctrl_b_next[nvmc_pkg::CB_RWS_LO +: 4];
    end
    pd_next = prm_next || sleep_lp;
    ready_next = (fsm_next == nvmc_pkg::FS_IDLE);
    // Registered read data
    if (reg_sel && !reg_wr) begin
      case (reg_addr)
        nvmc_pkg::OFS_CTRL_A: rdata_next = {25'h000_0000, cmd_reg};
        nvmc_pkg::OFS_CTRL_B: rdata_next = ctrl_b_reg;
        nvmc_pkg::OFS_STATUS: rdata_next = {23'h00_0000, sb_reg, 3'h0, nvme_reg, locke_reg,
                                            perr_reg, 1'b0, pd_reg};
        nvmc_pkg::OFS_ADDR: rdata_next = {10'h000, addr_reg};
        nvmc_pkg::OFS_LOCK: rdata_next = 32'(rl_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fsm_reg <= nvmc_pkg::FS_IDLE;
      op_reg <= nvmc_pkg::OP_NONE;
      cmd_reg <= 7'h00;
      ctrl_b_reg <= nvmc_pkg::RST_CTRL_B;
      addr_reg <= 22'h00_0000;
      aaddr_reg <= 22'h00_0000;
      rl_reg <= '0;
      dl_reg <= '0;
      prm_reg <= 1'b0;
      perr_reg <= 1'b0;
      locke_reg <= 1'b0;
      nvme_reg <= 1'b0;
      sb_reg <= 1'b0;
      boot_reg <= 1'b1;
      start_reg <= 1'b0;
      wipe_reg <= 1'b0;
      flush_reg <= 1'b0;
      pd_reg <= 1'b0;
      ready_reg <= 1'b1;
      mw_reg <= 4'h0;
      hw_reg <= 4'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      fsm_reg <= fsm_next;
      op_reg <= op_next;
      cmd_reg <= cmd_next;
      ctrl_b_reg <= ctrl_b_next;
      addr_reg <= addr_next;
      aaddr_reg <= aaddr_next;
      rl_reg <= rl_next;
      dl_reg <= dl_next;
      prm_reg <= prm_next;
      perr_reg <= perr_next;
      locke_reg <= locke_next;
      nvme_reg <= nvme_next;
      sb_reg <= sb_next;
      boot_reg <= boot_next;
      start_reg <= start_next;
      wipe_reg <= wipe_next;
      flush_reg <= flush_next;
      pd_reg <= pd_next;
      ready_reg <= ready_next;
      mw_reg <= mw_next;
      hw_reg <= hw_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops except array_byte, which is the constant SECURE_BYTE
  assign reg_rdata = rdata_reg;
  assign array_start = start_reg;
  assign array_op = op_reg;
  assign array_addr = aaddr_reg;
  assign array_byte = nvmc_pkg::SECURE_BYTE;
  assign region_lock = rl_reg;
  assign dregion_lock = dl_reg;
  assign ready = ready_reg;
  assign pbuf_clear = wipe_reg;
  assign cache_flush = flush_reg;
  assign cache_off = ctrl_b_reg[nvmc_pkg::CB_CACHE_OFF];
  assign miss_wait = mw_reg;
  assign hit_wait = hw_reg;
  assign power_down = pd_reg;
endmodule

// *** src/nvmc_sleep_power.sv ***
// Purpose: Automatic low-power entry and exit around system sleep
// Assumes: Sleep and access strobes come from logic on the same clock
// Notes: The reserved field value behaves as disabled
`timescale 1ns/1ps
module nvmc_sleep_power (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [1:0] sleep_power_field,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic mem_access,
  // State
  output logic low_power
);
  logic lp_reg;
  logic lp_next;
  logic enabled;

  // ==========================================================
  // Entry and exit selection
  always_comb begin
    enabled = (sleep_power_field == nvmc_pkg::SLEEP_WAKE_ACCESS) ||
      (sleep_power_field == nvmc_pkg::SLEEP_WAKE_EXIT);
    lp_next = lp_reg;
    if (!enabled) begin
      lp_next = 1'b0;
    end else if (lp_reg) begin
      // Exit event depends on the chosen wake style
      if (sleep_power_field == nvmc_pkg::SLEEP_WAKE_ACCESS) begin
        lp_next = ~mem_access;
      end else begin
        lp_next = ~sleep_exit;
      end
    end else begin
      lp_next = sleep_enter;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      lp_reg <= 1'b0;
    end else begin
      lp_reg <= lp_next;
    end
  end

  assign low_power = lp_reg;
endmodule
